/* File: rtl/mtw_core.sv */
// Our own choices: the address map and the APB register port.
`timescale 1ns/1ps
// Overview of operation
// - mask-zero test ANDs destination with mask, result only sets flags.
// - test operands are left untouched; nothing is written back.
// - zero flag set when masked result is zero, else cleared.
// - sign flag copies bit 7 of the masked result.
// - overflow flag always cleared by the tests.
// - operand byte with high nibble 1110b selects a working register.
// - opcode 72 tests working reg against working reg, one packed byte.
// - opcode 73 tests working reg against mask via working reg pointer.
// - opcode 74 is three bytes: mask register, then destination register.
// - opcode 75: pointer register byte, then destination register byte.
// - opcode 76: destination register, then immediate mask.
// - opcode 77: destination via pointer register, then immediate mask.
// - opcode 63 is mask-one test, working reg and indirect working mask.
// - opcode 65 is mask-one test, register dest and indirect mask.
// - opcode 67 is mask-one test, indirect dest and immediate mask.
// - mask-one test inverts destination before the AND.
// - watchdog is retriggerable and wraps to zero at terminal count; a terminal count resets the cpu unless an arm/refresh lands in the same cycle.
// - watchdog stays off after reset until first arm/refresh opcode.
// - each later arm/refresh restarts the count.
// - halt-keep opcode lets the watchdog count in halt mode.
// - without halt-keep the count freezes in halt mode.
// - halt-keep leaves the current count unchanged.
// - halt-keep before any arm has no effect.
module mtw_core #(
  parameter int AW = 8
) (
  input wire logic CLK_SYS, // 125 mhz cpu clock
  input wire logic RESET, // async reset, active high
  input wire logic PSEL, // apb select
  input wire logic PENABLE, // apb access phase
  input wire logic PWRITE, // apb write
  input wire logic [AW-1:0] PADDR, // apb byte address
  input wire logic [31:0] PWDATA, // apb write data
  output logic [31:0] PRDATA, // apb read data
  output logic PREADY, // apb ready
  output logic PSLVERR, // apb error, unmapped address
  input wire logic INSTR_VALID, // fetch byte valid
  input wire logic [7:0] INSTR_BYTE, // fetch byte
  output logic INSTR_READY, // block takes a byte
  input wire logic [3:0] WORK_BASE, // working register group
  input wire logic HALT_MODE, // cpu is halted
  output logic RF_RD_REQ, // register read request
  output logic [7:0] RF_RD_ADDR, // register read address
  input wire logic RF_RD_ACK, // read data valid pulse
  input wire logic [7:0] RF_RD_DATA, // read data
  output logic FLAG_Z, // zero flag
  output logic FLAG_S, // sign flag
  output logic FLAG_V, // overflow flag
  output logic FLAG_UPDATE, // flags valid pulse
  output logic CPU_RESET_REQ // watchdog reset pulse
);

  mtw_pkg::mtw_state_t state_reg, state_next;
  logic [7:0] op_reg;
  logic [7:0] b2_reg;
  logic [7:0] dst_addr_reg, dst_addr_next;
  logic [7:0] src_addr_reg, src_addr_next;
  logic [7:0] mask_reg, mask_next;
  logic [7:0] dval_reg;
  logic ready_reg;
  logic rd_req_reg;
  logic [7:0] rd_addr_reg;
  logic z_reg, s_reg, v_reg, upd_reg;
  logic [mtw_pkg::WD_W-1:0] tc_reg;
  logic [31:0] prdata_reg;
  logic pready_reg, pslverr_reg;
  logic take, ack, arm_op, keep_op;
  logic [3:0] fmt;
  logic [7:0] alu_res;
  logic alu_z, alu_s, alu_v;
  logic wd_en, wd_keep, wd_timeout;
  logic [mtw_pkg::WD_W-1:0] wd_count;

  // operand byte to register address, working registers folded in
  function automatic logic [7:0] xlate(input logic [7:0] b, input logic [3:0] base);
    xlate = (b[7:4] == mtw_pkg::WORK_NIB) ? {base, b[3:0]} : b;
  endfunction : xlate

  // opcode belongs to one of the two test families
  function automatic logic is_test(input logic [7:0] op);
    is_test = (op[7:4] == mtw_pkg::OPC_HI_MZ || op[7:4] == mtw_pkg::OPC_HI_MO) &&
              op[3:0] >= mtw_pkg::FMT_WW && op[3:0] <= mtw_pkg::FMT_IM;
  endfunction : is_test

  // states that hold a register read open
  function automatic logic is_read(input mtw_pkg::mtw_state_t st);
    is_read = (st == mtw_pkg::S_DPTR) || (st == mtw_pkg::S_SPTR) ||
              (st == mtw_pkg::S_SRC) || (st == mtw_pkg::S_DST);
  endfunction : is_read

  assign fmt = op_reg[3:0];
  assign take = INSTR_VALID & ready_reg;
  assign ack = RF_RD_ACK & rd_req_reg; // stray acks ignored
  assign arm_op = take && state_reg == mtw_pkg::S_OP && INSTR_BYTE == mtw_pkg::OPC_WD_ARM;
  assign keep_op = take && state_reg == mtw_pkg::S_OP && INSTR_BYTE == mtw_pkg::OPC_WD_KEEP;

  // sequencer: gather bytes, resolve pointers, fetch mask and destination
  always_comb begin
    state_next = state_reg;
    dst_addr_next = dst_addr_reg;
    src_addr_next = src_addr_reg;
    mask_next = mask_reg;
    unique case (state_reg)
      mtw_pkg::S_OP: begin
        if (take && is_test(INSTR_BYTE)) begin
          state_next = mtw_pkg::S_B2;
        end
      end
      mtw_pkg::S_B2: begin
        if (take) begin
          if (fmt == mtw_pkg::FMT_WW || fmt == mtw_pkg::FMT_WI) begin
            dst_addr_next = {WORK_BASE, INSTR_BYTE[7:4]};
            src_addr_next = {WORK_BASE, INSTR_BYTE[3:0]};
            state_next = (fmt == mtw_pkg::FMT_WI) ? mtw_pkg::S_SPTR : mtw_pkg::S_SRC;
          end else begin
            state_next = mtw_pkg::S_B3;
          end
        end
      end
      mtw_pkg::S_B3: begin
        if (take) begin
          unique case (fmt)
            mtw_pkg::FMT_RR: begin
              src_addr_next = xlate(b2_reg, WORK_BASE);
              dst_addr_next = xlate(INSTR_BYTE, WORK_BASE);
              state_next = mtw_pkg::S_SRC;
            end
            mtw_pkg::FMT_RI: begin
              src_addr_next = xlate(b2_reg, WORK_BASE);
              dst_addr_next = xlate(INSTR_BYTE, WORK_BASE);
              state_next = mtw_pkg::S_SPTR;
            end
            mtw_pkg::FMT_RM: begin
              dst_addr_next = xlate(b2_reg, WORK_BASE);
              mask_next = INSTR_BYTE;
              state_next = mtw_pkg::S_DST;
            end
            default: begin
              dst_addr_next = xlate(b2_reg, WORK_BASE);
              mask_next = INSTR_BYTE;
              state_next = mtw_pkg::S_DPTR;
            end
          endcase
        end
      end
      mtw_pkg::S_DPTR: begin
        if (ack) begin
          dst_addr_next = RF_RD_DATA;
          state_next = mtw_pkg::S_DST;
        end
      end
      mtw_pkg::S_SPTR: begin
        if (ack) begin
          src_addr_next = RF_RD_DATA;
          state_next = mtw_pkg::S_SRC;
        end
      end
      mtw_pkg::S_SRC: begin
        if (ack) begin
          mask_next = RF_RD_DATA;
          state_next = mtw_pkg::S_DST;
        end
      end
      mtw_pkg::S_DST: begin
        if (ack) begin
          state_next = mtw_pkg::S_EXEC;
        end
      end
      mtw_pkg::S_EXEC: begin
        state_next = mtw_pkg::S_OP;
      end
      default: begin
        state_next = mtw_pkg::S_OP;
      end
    endcase
  end

  // sequencer state and operand registers
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      state_reg <= mtw_pkg::S_OP;
      dst_addr_reg <= 8'h00;
      src_addr_reg <= 8'h00;
      mask_reg <= 8'h00;
    end else begin
      state_reg <= state_next;
      dst_addr_reg <= dst_addr_next;
      src_addr_reg <= src_addr_next;
      mask_reg <= mask_next;
    end
  end

  // opcode and second byte latches
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      op_reg <= 8'h00;
      b2_reg <= 8'h00;
    end else if (take) begin
      if (state_reg == mtw_pkg::S_OP) begin
        op_reg <= INSTR_BYTE;
      end
      if (state_reg == mtw_pkg::S_B2) begin
        b2_reg <= INSTR_BYTE;
      end
    end
  end

  // ready follows the next state so back-to-back bytes flow
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      ready_reg <= 1'b0;
    end else begin
      ready_reg <= (state_next == mtw_pkg::S_OP) || (state_next == mtw_pkg::S_B2) ||
                   (state_next == mtw_pkg::S_B3);
    end
  end

  // read-only port: the tests never write the register file
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      rd_req_reg <= 1'b0;
      rd_addr_reg <= 8'h00;
    end else begin
      rd_req_reg <= is_read(state_next);
      rd_addr_reg <= (state_next == mtw_pkg::S_SPTR || state_next == mtw_pkg::S_SRC) ?
                     src_addr_next : dst_addr_next;
    end
  end

  // destination value captured for the flag computation
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      dval_reg <= 8'h00;
    end else if (state_reg == mtw_pkg::S_DST && ack) begin
      dval_reg <= RF_RD_DATA;
    end
  end

  mtw_mask_alu u_alu (
    .dst(dval_reg),
    .mask(mask_reg),
    .mask_one(op_reg[7:4] == mtw_pkg::OPC_HI_MO),
    .res(alu_res),
    .zero(alu_z),
    .sign(alu_s),
    .ovf(alu_v)
  );

  // flags move only on a test; watchdog opcodes leave them alone
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      z_reg <= 1'b0;
      s_reg <= 1'b0;
      v_reg <= 1'b0;
      upd_reg <= 1'b0;
    end else begin
      upd_reg <= (state_reg == mtw_pkg::S_EXEC);
      if (state_reg == mtw_pkg::S_EXEC) begin
        z_reg <= alu_z;
        s_reg <= alu_s;
        v_reg <= alu_v;
      end
    end
  end

  mtw_watchdog #(
    .W(mtw_pkg::WD_W)
  ) u_wd (
    .clk(CLK_SYS),
    .rst(RESET),
    .arm(arm_op),
    .keep(keep_op),
    .halt(HALT_MODE),
    .tc(tc_reg),
    .en(wd_en),
    .keep_en(wd_keep),
    .timeout(wd_timeout),
    .count(wd_count)
  );

  // apb: one wait state, write lands on the completing edge
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h00000000;
    end else begin
      pready_reg <= PSEL & PENABLE & ~pready_reg;
      if (PSEL & PENABLE & ~pready_reg) begin
        pslverr_reg <= 1'b0;
        prdata_reg <= 32'h00000000;
        unique case (PADDR[7:0])
          mtw_pkg::ADDR_CTRL: prdata_reg <= {16'h0000, tc_reg};
          mtw_pkg::ADDR_STATUS: begin
            prdata_reg[mtw_pkg::ST_WD_EN] <= wd_en;
            prdata_reg[mtw_pkg::ST_HALT_KEEP] <= wd_keep;
            prdata_reg[mtw_pkg::ST_Z] <= z_reg;
            prdata_reg[mtw_pkg::ST_S] <= s_reg;
            prdata_reg[mtw_pkg::ST_V] <= v_reg;
            prdata_reg[mtw_pkg::ST_BUSY] <= (state_reg != mtw_pkg::S_OP);
          end
          mtw_pkg::ADDR_WDCOUNT: prdata_reg <= {16'h0000, wd_count};
          default: pslverr_reg <= 1'b1; // unmapped address
        endcase
      end
    end
  end

  // terminal count register, steers the watchdog period
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      tc_reg <= mtw_pkg::CTRL_TC_RST;
    end else if (PSEL & PENABLE & pready_reg & PWRITE && PADDR[7:0] == mtw_pkg::ADDR_CTRL) begin
      tc_reg <= PWDATA[15:0];
    end
  end

  assign PRDATA = prdata_reg;
  assign PREADY = pready_reg;
  assign PSLVERR = pslverr_reg;
  assign INSTR_READY = ready_reg;
  assign RF_RD_REQ = rd_req_reg;
  assign RF_RD_ADDR = rd_addr_reg;
  assign FLAG_Z = z_reg;
  assign FLAG_S = s_reg;
  assign FLAG_V = v_reg;
  assign FLAG_UPDATE = upd_reg;
  assign CPU_RESET_REQ = wd_timeout; // flop inside the watchdog

  property p_masked;
    @(posedge CLK_SYS) disable iff (RESET)
      state_reg == mtw_pkg::S_EXEC |-> alu_res ==
        (((op_reg[7:4] == mtw_pkg::OPC_HI_MO) ? ~dval_reg : dval_reg) & mask_reg);
  endproperty
  a_masked: assert property (p_masked) else $error("masked result wrong");

  property p_zflag;
    @(posedge CLK_SYS) disable iff (RESET)
      state_reg == mtw_pkg::S_EXEC |=> FLAG_UPDATE && FLAG_Z == ($past(alu_res) == 8'h00);
  endproperty
  a_zflag: assert property (p_zflag) else $error("zero flag wrong");

  property p_sflag;
    @(posedge CLK_SYS) disable iff (RESET)
      state_reg == mtw_pkg::S_EXEC |=> FLAG_S == $past(alu_res[7]);
  endproperty
  a_sflag: assert property (p_sflag) else $error("sign flag wrong");

  property p_vflag;
    @(posedge CLK_SYS) disable iff (RESET) FLAG_UPDATE |-> !FLAG_V;
  endproperty
  a_vflag: assert property (p_vflag) else $error("overflow flag not clear");

  property p_work_pack;
    @(posedge CLK_SYS) disable iff (RESET)
      take && state_reg == mtw_pkg::S_B2 && op_reg == 8'h72 |=>
        state_reg == mtw_pkg::S_SRC && src_addr_reg == {$past(WORK_BASE), $past(INSTR_BYTE[3:0])} &&
        dst_addr_reg == {$past(WORK_BASE), $past(INSTR_BYTE[7:4])};
  endproperty
  a_work_pack: assert property (p_work_pack) else $error("packed working operands wrong");

  property p_work_nib;
    @(posedge CLK_SYS) disable iff (RESET)
      take && state_reg == mtw_pkg::S_B3 && op_reg == 8'h74 && INSTR_BYTE[7:4] == mtw_pkg::WORK_NIB |=>
        dst_addr_reg == {$past(WORK_BASE), $past(INSTR_BYTE[3:0])};
  endproperty
  a_work_nib: assert property (p_work_nib) else $error("working register not selected");

  property p_imm;
    @(posedge CLK_SYS) disable iff (RESET)
      take && state_reg == mtw_pkg::S_B3 && op_reg == 8'h76 |=>
        state_reg == mtw_pkg::S_DST && mask_reg == $past(INSTR_BYTE) && RF_RD_REQ;
  endproperty
  a_imm: assert property (p_imm) else $error("immediate mask not taken");

  property p_dptr;
    @(posedge CLK_SYS) disable iff (RESET)
      state_reg == mtw_pkg::S_DPTR && ack |=> dst_addr_reg == $past(RF_RD_DATA) ##0 RF_RD_ADDR == dst_addr_reg;
  endproperty
  a_dptr: assert property (p_dptr) else $error("indirect destination not followed");

  c_mask_zero: cover property (@(posedge CLK_SYS) disable iff (RESET)
    state_reg == mtw_pkg::S_EXEC && op_reg[7:4] == mtw_pkg::OPC_HI_MZ);
  c_mask_one: cover property (@(posedge CLK_SYS) disable iff (RESET)
    state_reg == mtw_pkg::S_EXEC && op_reg[7:4] == mtw_pkg::OPC_HI_MO && alu_z);
  c_arm: cover property (@(posedge CLK_SYS) disable iff (RESET) arm_op && wd_en);

endmodule : mtw_core

/* File: rtl/mtw_mask_alu.sv */
`timescale 1ns/1ps
module mtw_mask_alu (
  input wire logic [7:0] dst, // destination operand value
  input wire logic [7:0] mask, // source mask
  input wire logic mask_one, // invert destination first
  output logic [7:0] res, // masked result, flags only
  output logic zero, // result is zero
  output logic sign, // result bit 7
  output logic ovf // overflow, always clear
);

  // result never goes back to the register file
  always_comb begin
    res = (mask_one ? ~dst : dst) & mask;
    zero = (res == 8'h00);
    sign = res[7];
    ovf = 1'b0;
  end

endmodule : mtw_mask_alu

/* File: rtl/mtw_pkg.sv */
package mtw_pkg;

  // opcode high nibbles select the test flavour
  localparam logic [3:0] OPC_HI_MZ = 4'h7; // mask_zero_test family
  localparam logic [3:0] OPC_HI_MO = 4'h6; // mask_one_test family

  // opcode low nibbles select the operand format
  localparam logic [3:0] FMT_WW = 4'h2; // working reg, working reg
  localparam logic [3:0] FMT_WI = 4'h3; // working reg, working_reg_indirect_mode mask
  localparam logic [3:0] FMT_RR = 4'h4; // reg, reg (mask byte first)
  localparam logic [3:0] FMT_RI = 4'h5; // reg, file_reg_indirect_mode mask
  localparam logic [3:0] FMT_RM = 4'h6; // reg, immediate_mode mask
  localparam logic [3:0] FMT_IM = 4'h7; // indirect reg, immediate_mode mask

  // single-byte watchdog opcodes
  localparam logic [7:0] OPC_WD_ARM = 8'h5f; // watchdog_arm_refresh
  localparam logic [7:0] OPC_WD_KEEP = 8'h4f; // watchdog_halt_keep

  // high nibble that marks a working register operand
  localparam logic [3:0] WORK_NIB = 4'he;

  // apb register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_WDCOUNT = 8'h08;

  // watchdog terminal count width and reset value
  localparam int WD_W = 16;
  localparam logic [15:0] CTRL_TC_RST = 16'hffff;

  // status register bit positions
  localparam int ST_WD_EN = 0;
  localparam int ST_HALT_KEEP = 1;
  localparam int ST_Z = 2;
  localparam int ST_S = 3;
  localparam int ST_V = 4;
  localparam int ST_BUSY = 5;

  // sequencer states
  typedef enum logic [3:0] {
    S_OP = 4'h0,
    S_B2 = 4'h1,
    S_B3 = 4'h2,
    S_DPTR = 4'h3,
    S_SPTR = 4'h4,
    S_SRC = 4'h5,
    S_DST = 4'h6,
    S_EXEC = 4'h7
  } mtw_state_t;

endpackage : mtw_pkg

/* File: rtl/mtw_watchdog.sv */
`timescale 1ns/1ps
module mtw_watchdog #(
  parameter int W = 16
) (
  input wire logic clk, // cpu clock
  input wire logic rst, // async reset, high
  input wire logic arm, // arm/refresh opcode executed
  input wire logic keep, // halt-keep opcode executed
  input wire logic halt, // cpu in halt mode
  input wire logic [W-1:0] tc, // terminal count
  output logic en, // watchdog armed
  output logic keep_en, // keeps counting in halt
  output logic timeout, // one-cycle reset request
  output logic [W-1:0] count // current count
);

  logic run;

  // frozen in halt unless halt-keep was executed
  assign run = en & (~halt | keep_en);

  // disabled after reset until the first arm
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      en <= 1'b0;
    end else if (arm) begin
      en <= 1'b1;
    end
  end

  // halt-keep only counts once armed
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      keep_en <= 1'b0;
    end else if (keep & en) begin
      keep_en <= 1'b1;
    end
  end

  // retriggerable count; halt-keep does not touch it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count <= '0;
    end else if (arm) begin
      count <= '0;
    end else if (run) begin
      count <= (count == tc) ? '0 : count + 1'b1;
    end
  end

  // terminal count fires the cpu reset request
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      timeout <= 1'b0;
    end else begin
      timeout <= run & ~arm & (count == tc);
    end
  end

  property p_arm_restart;
    @(posedge clk) disable iff (rst) arm |=> en && count == '0;
  endproperty
  a_arm_restart: assert property (p_arm_restart) else $error("arm did not restart watchdog");

  property p_stay_off;
    @(posedge clk) disable iff (rst) !en && !arm |=> !en && !timeout;
  endproperty
  a_stay_off: assert property (p_stay_off) else $error("watchdog active without arm");

  property p_halt_freeze;
    @(posedge clk) disable iff (rst) en && halt && !keep_en && !arm |=> count == $past(count);
  endproperty
  a_halt_freeze: assert property (p_halt_freeze) else $error("count moved in halt");

  property p_keep_unarmed;
    @(posedge clk) disable iff (rst) keep && !en && !keep_en |=> !keep_en;
  endproperty
  a_keep_unarmed: assert property (p_keep_unarmed) else $error("halt-keep took effect unarmed");

  property p_terminal;
    @(posedge clk) disable iff (rst) run && !arm && count == tc |=> timeout && count == '0;
  endproperty
  a_terminal: assert property (p_terminal) else $error("no reset at terminal count");

  property p_keep_count;
    @(posedge clk) disable iff (rst) keep && !arm && run && count != tc |=> count == $past(count) + 1'b1;
  endproperty
  a_keep_count: assert property (p_keep_count) else $error("halt-keep disturbed the count");

  c_timeout: cover property (@(posedge clk) disable iff (rst) timeout);
  c_halt_run: cover property (@(posedge clk) disable iff (rst) halt && keep_en && run);

endmodule : mtw_watchdog

/* File: test/mask_test_and_watchdog_ops_tb_top.sv */
`timescale 1ns/1ps
module mask_test_and_watchdog_ops_tb_top;
  logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, iv = 0, halt = 0;
  logic [7:0] paddr = 8'h00, ib = 8'h00, raddr, rdata, seed = 8'h2e;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [3:0] base = 4'h0;
  logic [1:0] lat = 2'h0;
  logic pready, pslverr, irdy, rreq, rack, fz, fs, fv, fup, wdr;
  int n_mismatch = 0, total_checks = 0, cyc = 0, n_wd = 0;
  logic [7:0] q_seen[$], q_exp[$];

  always #4 clk = ~clk;

  mtw_core i_dut (.CLK_SYS(clk), .RESET(rst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .INSTR_VALID(iv), .INSTR_BYTE(ib),
    .INSTR_READY(irdy), .WORK_BASE(base), .HALT_MODE(halt), .RF_RD_REQ(rreq), .RF_RD_ADDR(raddr),
    .RF_RD_ACK(rack), .RF_RD_DATA(rdata), .FLAG_Z(fz), .FLAG_S(fs), .FLAG_V(fv), .FLAG_UPDATE(fup),
    .CPU_RESET_REQ(wdr));
  mtw_rf_model i_rf (.clk(clk), .rst(rst), .req(rreq), .addr(raddr), .lat(lat), .ack(rack), .data(rdata));

  // 8-bit xorshift, fixed start
  function logic [7:0] rnd();
    seed ^= seed << 7;
    seed ^= seed >> 5;
    seed ^= seed << 3;
    return seed;
  endfunction : rnd

  function automatic logic [7:0] wa(input logic [3:0] bs, input logic [7:0] b);
    return (b[7:4] == 4'he) ? {bs, b[3:0]} : b;
  endfunction : wa

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : final_report

  // hang guard, well above the expected run of under two thousand cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      final_report();
    end
  end

  // capture register read addresses and watchdog pulses as the design sees them
  always @(posedge clk) begin
    if (rreq === 1'b1 && rack === 1'b1) q_seen.push_back(raddr);
    if (wdr === 1'b1) n_wd++;
  end

  // one apb transfer; one idle edge after so psel is never set twice in one step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    chk("pslverr", a > 8'h08, pslverr);
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask : apb

  task automatic send(input logic [7:0] b);
    iv <= 1'b1;
    ib <= b;
    do @(posedge clk); while (irdy !== 1'b1);
  endtask : send

  // one mask test with random operands, checked against the reference
  task automatic mtest(input logic [7:0] op);
    logic [7:0] b2, b3, sa, da, m, d, r, t;
    logic [3:0] bs;
    int k;
    for (k = 0; k < 256; k++) i_rf.mem[k] = rnd();
    t = rnd();
    bs = t[3:0];
    b2 = rnd();
    b3 = rnd();
    if (t[6]) b2[7:4] = 4'he;
    if (t[7]) b3[7:4] = 4'he;
    q_seen.delete();
    q_exp.delete();
    if (op[3:1] == 3'b001) begin
      sa = {bs, b2[3:0]};
      da = {bs, b2[7:4]};
    end else begin
      sa = wa(bs, b2);
      da = wa(bs, b3);
    end
    if (op[0]) begin
      q_exp.push_back(sa);
      sa = i_rf.mem[sa];
    end
    // both immediate forms name the destination in byte two, directly or through a pointer
    if (op[3:1] == 3'b011) da = sa;
    if (op[3:0] < 4'h6) q_exp.push_back(sa);
    q_exp.push_back(da);
    m = (op[3:1] == 3'b011) ? b3 : i_rf.mem[sa];
    d = i_rf.mem[da];
    r = (op[7:4] == mtw_pkg::OPC_HI_MO) ? (~d & m) : (d & m);
    base <= bs;
    lat <= t[5:4];
    send(op);
    send(b2);
    if (op[3:0] > 4'h3) send(b3);
    iv <= 1'b0;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (fup !== 1'b1 && k < 100);
    chk("flag_update", 1, fup);
    chk("flag_z", r == 8'h00, fz);
    chk("flag_s", r[7], fs);
    chk("flag_v", 0, fv);
    chk("read_count", q_exp.size(), q_seen.size());
    foreach (q_exp[j]) chk("read_addr", q_exp[j], q_seen[j]);
  endtask : mtest

  // main sequence
  initial begin
    logic [31:0] rd, c1;
    logic [2:0] fl;
    int i;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    apb(1'b0, mtw_pkg::ADDR_CTRL, 32'h0, rd);
    chk("ctrl_reset", {16'h0000, mtw_pkg::CTRL_TC_RST}, rd);
    apb(1'b0, 8'h0c, 32'h0, rd);
    chk("unmapped_read", 0, rd);
    apb(1'b1, mtw_pkg::ADDR_CTRL, 32'h8, rd);
    for (i = 0; i < 96; i++) mtest({(i % 2) ? 4'h6 : 4'h7, 4'(2 + (i / 2) % 6)});
    $display("mask tests done");
    send(mtw_pkg::OPC_WD_KEEP);
    iv <= 1'b0;
    repeat (20) @(posedge clk);
    apb(1'b0, mtw_pkg::ADDR_STATUS, 32'h0, rd);
    chk("status_idle", 0, rd[1:0]);
    chk("wd_idle", 0, n_wd);
    fl = {fz, fs, fv};
    for (i = 0; i < 12; i++) begin
      send(mtw_pkg::OPC_WD_ARM);
      iv <= 1'b0;
      repeat (3) @(posedge clk);
    end
    halt <= 1'b1;
    chk("wd_refresh", 0, n_wd);
    chk("flags_kept", fl, {fz, fs, fv});
    apb(1'b0, mtw_pkg::ADDR_WDCOUNT, 32'h0, c1);
    repeat (20) @(posedge clk);
    apb(1'b0, mtw_pkg::ADDR_WDCOUNT, 32'h0, rd);
    chk("count_frozen", c1, rd);
    chk("wd_halted", 0, n_wd);
    halt <= 1'b0;
    send(mtw_pkg::OPC_WD_KEEP);
    iv <= 1'b0;
    halt <= 1'b1;
    apb(1'b0, mtw_pkg::ADDR_STATUS, 32'h0, rd);
    chk("status_keep", 2'b11, rd[1:0]);
    #1 n_wd = 0;
    repeat (27) @(posedge clk);
    #1 chk("wd_pulses", 3, n_wd);
    $display("watchdog tests done");
    final_report();
  end
endmodule : mask_test_and_watchdog_ops_tb_top

/* File: test/mtw_rf_model.sv */
`timescale 1ns/1ps
module mtw_rf_model (
  input wire logic clk, // cpu clock
  input wire logic rst, // async reset, high
  input wire logic req, // read request
  input wire logic [7:0] addr, // read address
  input wire logic [1:0] lat, // wait cycles before ack
  output logic ack, // data valid pulse
  output logic [7:0] data // read data
);
  logic [7:0] mem [256];
  logic [1:0] wait_reg;

  // answer after lat idle cycles; off-ack data flips each cycle so stale reads show
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ack <= 1'b0;
      data <= 8'h00;
      wait_reg <= 2'h0;
    end else begin
      ack <= 1'b0;
      data <= ~data;
      if (req && !ack) begin
        if (wait_reg == lat) begin
          ack <= 1'b1;
          data <= mem[addr];
          wait_reg <= 2'h0;
        end else begin
          wait_reg <= wait_reg + 2'h1;
        end
      end
    end
  end
endmodule : mtw_rf_model
